// file: design/homing_defs.svh
// Purpose: Offsets, reset values, limits and codes of the homing sequencer
// Assumes: APB byte addressing, each register one aligned 32-bit word
// Notes:   Definitions only
`ifndef HOMING_DEFS_SVH
`define HOMING_DEFS_SVH

`define ADDR_CONFIG     8'h00
`define ADDR_APPROACH   8'h04
`define ADDR_LEAVE      8'h08
`define ADDR_OFF_HIGH   8'h0C
`define ADDR_OFF_LOW    8'h10
`define ADDR_OUT_ASSIGN 8'h14
`define ADDR_IN_ASSIGN  8'h18
`define ADDR_CTRL_MODE  8'h1C
`define ADDR_STATUS     8'h20

`define RST_CONFIG      12'h000
`define RST_APPROACH    12'h5DC
`define RST_LEAVE       12'h01E
`define RST_OFFSET      14'h0000
`define RST_OUT_ASSIGN  12'h000
`define RST_IN_A        2'h0
`define RST_IN_B        2'h1

`define MAX_APPROACH    12'hBB8
`define MAX_LEAVE       12'h0C8
`define MAX_OFFSET      14'h270F
`define OFFSET_SCALE    27'h0002710

`define DIGIT_ON        4'h1
`define ASSIGN_HOME     4'h8
`define MODE_POSITION   2'h0
`define MODE_SWITCHING  2'h1

`endif

// file: design/homing_pkg.sv
// Purpose: Types shared by the homing sequencer files
// Assumes: Nothing
// Notes:   Constants live in homing_defs.svh
package homing_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_APPROACH, ST_LEAVE, ST_OFFSET, ST_DONE
  } home_state_t;

  typedef struct packed {
    logic        run;
    logic        dir;
    logic [11:0] speed;
  } motion_t;
endpackage : homing_pkg

// file: design/offset_counter.sv
// Purpose: Counts encoder pulses down from a loaded target
// Assumes: One feedback pulse per cycle at most
// Notes:   done_o is low the cycle after load, valid the cycle after that
`timescale 1ns/1ps
module offset_counter #(
  parameter int W = 27
) (
  input  wire logic         clock_i,
  input  wire logic         rstn_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] target_i,
  input  wire logic         pulse_i,
  output logic              done_o
);
  logic [W-1:0] remaining;
  logic [W-1:0] next_remaining;
  logic         armed;
  logic         next_armed;
  logic         next_done;

  always_comb begin
    next_remaining = remaining;
    next_armed     = armed;
    next_done      = armed && (remaining == '0);
    if (load_i) begin
      next_remaining = target_i;
      next_armed     = 1'b1;
      next_done      = 1'b0;
    end else if (armed && pulse_i && remaining != '0) begin
      next_remaining = remaining - W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      remaining <= '0;
      armed     <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      remaining <= next_remaining;
      armed     <= next_armed;
      done_o    <= next_done;
    end
  end
endmodule : offset_counter

// file: design/servo_homing_sequencer.sv
// Purpose: Homing sequencer of a servo drive in position control
// Assumes: All inputs synchronous to clock_i; APB slave, no wait states
// Notes:   Power-cycled settings are copied on power_cycle_i
// Behaviour
// - Config digit 0 picks direction, 0 forward, 1 reverse.
// - Config digit 1: 0 reverse to seek index, 1 seek index directly.
// - Config digit 2: 0 disables homing, 1 starts on start rising edge.
// - Homing starts only while positioning complete is on.
// - Host reference pulses are blocked while homing runs.
// - No homing while switching control mode is selected.
// - Control mode writes are refused during homing.
// - New homing config applies only after a power cycle.
// - Approach speed 0 to 3000 rpm, default 1500, applies at once.
// - Offset is high times ten thousand plus low, each 0 to 9999.
// - Start edge drives the motor at approach speed.
// - Origin seen switches to leave speed in the chosen search style.
// - Origin then index pulse starts offset pulse counting.
// - Offset done stops motor, asserts complete, ends homing.
// - Homing complete output is active low.
// - Digit equal to 8 in output assign picks the terminal pair.
// - Input terminal assignment applies only after a power cycle.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "homing_defs.svh"
module servo_homing_sequencer
  import homing_pkg::*;
#(
  parameter int OFF_W = 27
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        power_cycle_i,
  input  wire logic [3:0]  input_terms_i,
  input  wire logic        positioning_complete_i,
  input  wire logic        index_pulse_i,
  input  wire logic        feedback_pulse_i,
  input  wire logic        ref_pulse_i,
  output logic             ref_pulse_o,
  output motion_t          motion_o,
  output logic [2:0]       home_done_n_o
);
  function automatic logic [13:0] clamp14(logic [31:0] v, logic [13:0] mx);
    clamp14 = (v > 32'(mx)) ? mx : v[13:0];
  endfunction : clamp14

  logic [11:0] cfg_pend, cfg_act, next_cfg_pend, next_cfg_act;
  logic [11:0] app_spd, next_app_spd, lv_spd, next_lv_spd;
  logic [13:0] off_hi, next_off_hi, off_lo, next_off_lo;
  logic [11:0] oa_pend, oa_act, next_oa_pend, next_oa_act;
  logic [1:0]  ia_a_pend, ia_b_pend, ia_a_act, ia_b_act;
  logic [1:0]  next_ia_a_pend, next_ia_b_pend, next_ia_a_act, next_ia_b_act;
  logic [1:0]  ctrl_mode, next_ctrl_mode;
  logic        refused, next_refused;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  logic        busy, wr_en, rd_setup, hit;
  home_state_t state, next_state;

  assign busy     = (state != ST_IDLE) && (state != ST_DONE);
  assign wr_en    = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_setup = psel_i && !penable_i;
  assign hit      = paddr_i <= `ADDR_STATUS && paddr_i[1:0] == 2'h0;

  // Register file and APB slave
  always_comb begin
    next_cfg_pend  = cfg_pend;
    next_cfg_act   = cfg_act;
    next_app_spd   = app_spd;
    next_lv_spd    = lv_spd;
    next_off_hi    = off_hi;
    next_off_lo    = off_lo;
    next_oa_pend   = oa_pend;
    next_oa_act    = oa_act;
    next_ia_a_pend = ia_a_pend;
    next_ia_b_pend = ia_b_pend;
    next_ia_a_act  = ia_a_act;
    next_ia_b_act  = ia_b_act;
    next_ctrl_mode = ctrl_mode;
    next_refused   = refused;
    next_pready    = rd_setup;
    next_pslverr   = rd_setup && !hit;
    next_prdata    = 32'h0000_0000;
    if (wr_en) begin
      case (paddr_i)
        `ADDR_CONFIG:     next_cfg_pend = pwdata_i[11:0];
        `ADDR_APPROACH:
          next_app_spd = 12'(clamp14(pwdata_i, 14'(`MAX_APPROACH)));
        `ADDR_LEAVE:
          next_lv_spd = 12'(clamp14(pwdata_i, 14'(`MAX_LEAVE)));
        `ADDR_OFF_HIGH:   next_off_hi = clamp14(pwdata_i, `MAX_OFFSET);
        `ADDR_OFF_LOW:    next_off_lo = clamp14(pwdata_i, `MAX_OFFSET);
        `ADDR_OUT_ASSIGN: next_oa_pend = pwdata_i[11:0];
        `ADDR_IN_ASSIGN: begin
          next_ia_a_pend = pwdata_i[1:0];
          next_ia_b_pend = pwdata_i[5:4];
        end
        `ADDR_CTRL_MODE: begin
          if (busy) begin
            next_refused = 1'b1;
          end else begin
            next_ctrl_mode = pwdata_i[1:0];
          end
        end
        `ADDR_STATUS: begin
          if (pwdata_i[8]) begin
            next_refused = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (power_cycle_i) begin
      next_cfg_act  = cfg_pend;
      next_oa_act   = oa_pend;
      next_ia_a_act = ia_a_pend;
      next_ia_b_act = ia_b_pend;
    end
    if (rd_setup && !pwrite_i) begin
      case (paddr_i)
        `ADDR_CONFIG:     next_prdata = {20'h0, cfg_pend};
        `ADDR_APPROACH:   next_prdata = {20'h0, app_spd};
        `ADDR_LEAVE:      next_prdata = {20'h0, lv_spd};
        `ADDR_OFF_HIGH:   next_prdata = {18'h0, off_hi};
        `ADDR_OFF_LOW:    next_prdata = {18'h0, off_lo};
        `ADDR_OUT_ASSIGN: next_prdata = {20'h0, oa_pend};
        `ADDR_IN_ASSIGN:
          next_prdata = {26'h0, ia_b_pend, 2'h0, ia_a_pend};
        `ADDR_CTRL_MODE:  next_prdata = {30'h0, ctrl_mode};
        `ADDR_STATUS:
          next_prdata = {23'h0, refused, 3'h0, busy, 1'b0, 3'(state)};
        default:          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_pend  <= `RST_CONFIG;
      cfg_act   <= `RST_CONFIG;
      app_spd   <= `RST_APPROACH;
      lv_spd    <= `RST_LEAVE;
      off_hi    <= `RST_OFFSET;
      off_lo    <= `RST_OFFSET;
      oa_pend   <= `RST_OUT_ASSIGN;
      oa_act    <= `RST_OUT_ASSIGN;
      ia_a_pend <= `RST_IN_A;
      ia_b_pend <= `RST_IN_B;
      ia_a_act  <= `RST_IN_A;
      ia_b_act  <= `RST_IN_B;
      ctrl_mode <= `MODE_POSITION;
      refused   <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      cfg_pend  <= next_cfg_pend;
      cfg_act   <= next_cfg_act;
      app_spd   <= next_app_spd;
      lv_spd    <= next_lv_spd;
      off_hi    <= next_off_hi;
      off_lo    <= next_off_lo;
      oa_pend   <= next_oa_pend;
      oa_act    <= next_oa_act;
      ia_a_pend <= next_ia_a_pend;
      ia_b_pend <= next_ia_b_pend;
      ia_a_act  <= next_ia_a_act;
      ia_b_act  <= next_ia_b_act;
      ctrl_mode <= next_ctrl_mode;
      refused   <= next_refused;
      prdata_o  <= next_prdata;
      pready_o  <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  // Sequencer
  logic             start_lvl, origin_lvl, start_prev, start_edge, can_start;
  logic             next_start_prev, cnt_load, next_cnt_load, cnt_done;
  logic             next_ref_pulse;
  logic [2:0]       next_home_n;
  logic [OFF_W-1:0] off_target;
  motion_t          next_motion;

  assign start_lvl  = input_terms_i[ia_a_act];
  assign origin_lvl = input_terms_i[ia_b_act];
  assign start_edge = start_lvl && !start_prev;
  assign can_start  = cfg_act[11:8] == `DIGIT_ON && start_edge
                      && positioning_complete_i
                      && ctrl_mode != `MODE_SWITCHING;
  // Wide enough for 9999 * 10000 + 9999
  assign off_target = OFF_W'(off_hi) * OFF_W'(`OFFSET_SCALE)
                      + OFF_W'(off_lo);

  offset_counter #(.W(OFF_W)) u_offset (
    .clock_i  (clock_i),
    .rstn_i   (rstn_i),
    .load_i   (cnt_load),
    .target_i (off_target),
    .pulse_i  (feedback_pulse_i),
    .done_o   (cnt_done)
  );

  always_comb begin
    next_state      = state;
    next_start_prev = start_lvl;
    next_cnt_load   = 1'b0;
    next_motion     = motion_o;
    next_home_n     = home_done_n_o;
    case (state)
      ST_IDLE, ST_DONE: begin
        next_motion.run = 1'b0;
        if (can_start) begin
          next_state      = ST_APPROACH;
          next_motion.run = 1'b1;
          next_motion.dir = cfg_act[0];
          next_home_n     = 3'b111;
        end
      end
      ST_APPROACH: begin
        next_motion.speed = app_spd;
        if (origin_lvl) begin
          next_state      = ST_LEAVE;
          next_motion.speed = lv_spd;
          // Style 0 turns back over the sensor before seeking the index
          next_motion.dir = cfg_act[4] ? cfg_act[0] : !cfg_act[0];
        end
      end
      ST_LEAVE: begin
        next_motion.speed = lv_spd;
        if (index_pulse_i) begin
          next_state    = ST_OFFSET;
          next_cnt_load = 1'b1;
        end
      end
      ST_OFFSET: begin
        next_motion.speed = lv_spd;
        if (cnt_done && !cnt_load) begin
          next_state      = ST_DONE;
          next_motion.run = 1'b0;
          for (int k = 0; k < 3; k++) begin
            next_home_n[k] = oa_act[4*k +: 4] != `ASSIGN_HOME;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (next_state == ST_APPROACH) begin
      next_motion.speed = app_spd;
    end
    // Gated by the current state, so the block lags the run output by one cycle
    next_ref_pulse = ref_pulse_i && !busy;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state         <= ST_IDLE;
      start_prev    <= 1'b0;
      cnt_load      <= 1'b0;
      motion_o      <= '0;
      home_done_n_o <= 3'b111;
      ref_pulse_o   <= 1'b0;
    end else begin
      state         <= next_state;
      start_prev    <= next_start_prev;
      cnt_load      <= next_cnt_load;
      motion_o      <= next_motion;
      home_done_n_o <= next_home_n;
      ref_pulse_o   <= next_ref_pulse;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_start;
    state inside {ST_IDLE, ST_DONE} && can_start;
  endsequence
  sequence s_index;
    state == ST_LEAVE && index_pulse_i;
  endsequence

  a_start_gate: assert property (
    state == ST_IDLE && cfg_act[11:8] != `DIGIT_ON |=> state == ST_IDLE)
    else $error("homing started while disabled");
  a_positioning_complete_gate: assert property (
    state == ST_IDLE && !positioning_complete_i |=> state == ST_IDLE)
    else $error("homing started without positioning complete");
  a_switch_gate: assert property (
    state == ST_IDLE && ctrl_mode == `MODE_SWITCHING |=> state == ST_IDLE)
    else $error("homing started in switching mode");
  a_start_move: assert property (
    s_start |=> motion_o.run && motion_o.speed == $past(app_spd)
                && motion_o.dir == $past(cfg_act[0]))
    else $error("approach move wrong");
  a_leave_dir: assert property (
    state == ST_APPROACH && origin_lvl |=> state == ST_LEAVE
    && motion_o.speed == $past(lv_spd)
    && motion_o.dir == ($past(cfg_act[4]) ? $past(motion_o.dir)
                                          : !$past(motion_o.dir)))
    else $error("leave direction wrong");
  a_ref_block: assert property (
    busy |=> !ref_pulse_o)
    else $error("reference pulse passed during homing");
  a_mode_hold: assert property (
    busy && wr_en && paddr_i == `ADDR_CTRL_MODE
    |=> $stable(ctrl_mode) && refused)
    else $error("mode changed during homing");
  a_zero_offset: assert property (
    (s_index and (off_hi == 14'h0 && off_lo == 14'h0))
    |=> state == ST_OFFSET ##3 state == ST_DONE)
    else $error("zero offset did not finish in time");
  a_done_out: assert property (
    state == ST_OFFSET ##1 state == ST_DONE
    |-> !motion_o.run && home_done_n_o == ~{oa_act[11:8] == `ASSIGN_HOME,
        oa_act[7:4] == `ASSIGN_HOME, oa_act[3:0] == `ASSIGN_HOME})
    else $error("completion output wrong");
  a_cfg_latch: assert property (
    !power_cycle_i |=> $stable(cfg_act))
    else $error("config applied without power cycle");
endmodule : servo_homing_sequencer

// file: dv/home_partner.sv
// Purpose: Origin sensor and encoder seen by the homing sequencer
// Assumes: The axis moves only while motion run is high
// Notes:   delay_i sets how slowly origin and index appear
`timescale 1ns/1ps
module home_partner
  import homing_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire motion_t    motion_i,
  input  wire logic [7:0] delay_i,
  output logic            origin_o,
  output logic            index_o,
  output logic            feedback_o
);
  logic [7:0] cnt;
  logic [1:0] phase;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {cnt, phase, origin_o, index_o, feedback_o} <= '0;
    end else begin
      index_o    <= 1'b0;
      feedback_o <= 1'b0;
      cnt        <= cnt + 8'h01;
      if (motion_i.run !== 1'b1) begin
        {cnt, phase, origin_o} <= '0; // Sensor clears once stopped
      end else if (phase == 2'h0 && cnt >= delay_i) begin
        {cnt, phase, origin_o} <= {8'h00, 2'h1, 1'b1};
      end else if (phase == 2'h1 && cnt >= delay_i) begin
        {cnt, phase, index_o} <= {8'h00, 2'h2, 1'b1};
      end else if (phase == 2'h2) begin
        // Spaced pulses so the stop lands between two of them
        feedback_o <= (cnt[1:0] == 2'h3);
      end
    end
  end
endmodule : home_partner

// file: dv/servo_homing_sequencer_tb.sv
// Purpose: Self-checking bench for the homing sequencer
// Assumes: Partner model stands in for sensor and encoder
// Notes:   Offset high is 1 in one run only, to keep runs short
`timescale 1ns/1ps
`include "homing_defs.svh"
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  err_count++; $display("Error %s exp %h got %h", nm, ex, got); end end
module servo_homing_sequencer_tb;
  import homing_pkg::*;
  logic        clock_i, rstn_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, delay;
  logic [31:0] pwdata, prdata, v;
  logic        pcyc, poscomp, ref_out, origin, index, fb, e;
  logic        ref_in = 1'b0;
  logic        prev_run, prev_ref;
  logic [2:0]  done_n;
  logic [2:0]  up = 3'h0;
  logic [3:0]  terms;
  motion_t     motion;
  int          err_count, checked;
  logic [31:0] rst_tab [9] = '{32'h0, 32'h5DC, 32'h1E, 32'h0, 32'h0,
                               32'h0, 32'h10, 32'h0, 32'h0};
  logic [11:0] asg_tab [4] = '{12'h008, 12'h080, 12'h800, 12'h888};

  servo_homing_sequencer DUT (.clock_i(clock_i), .rstn_i(rstn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .power_cycle_i(pcyc),
    .input_terms_i({terms[3:2], origin, terms[0]}),
    .positioning_complete_i(poscomp), .index_pulse_i(index),
    .feedback_pulse_i(fb), .ref_pulse_i(ref_in), .ref_pulse_o(ref_out),
    .motion_o(motion), .home_done_n_o(done_n));
  home_partner partner (.clock_i(clock_i), .rstn_i(rstn_i),
    .motion_i(motion), .delay_i(delay), .origin_o(origin),
    .index_o(index), .feedback_o(fb));

  always #10 clock_i = ~clock_i;

  // Host pulses arrive at random; they pass only while idle
  always @(posedge clock_i) begin
    if (prev_run === 1'b1) `CHECK("ref_out", 1'b0, ref_out)
    else if (&up) `CHECK("ref_pass", prev_ref, ref_out)
    up       <= {up[1:0], rstn_i};
    prev_run <= motion.run;
    prev_ref <= ref_in;
    ref_in   <= 1'($urandom_range(1));
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do @(posedge clock_i); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) err_count++;
    v = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pcycle;
    pcyc <= 1'b1;
    @(posedge clock_i);
    pcyc <= 1'b0;
  endtask : pcycle

  task automatic try_start(input int lane, input logic ex);
    int n;
    terms[lane] <= 1'b0;
    repeat (3) @(posedge clock_i);
    terms[lane] <= 1'b1;
    for (n = 0; n < 6 && motion.run !== 1'b1; n++) @(posedge clock_i);
    `CHECK("run", ex, motion.run)
  endtask : try_start

  function automatic logic [2:0] exp_done(input logic [11:0] a);
    return ~{a[11:8] == 4'h8, a[7:4] == 4'h8, a[3:0] == 4'h8};
  endfunction : exp_done

  task automatic home(input int i);
    logic [11:0] ap, lv;
    int          hi, lo, n, pulses;
    ap = 12'($urandom_range(3000));
    lv = 12'($urandom_range(60));
    hi = (i == 3);
    lo = (i == 0) ? 0 : $urandom_range(20);
    delay <= 8'(16 + $urandom_range(15));
    apb(1'b1, `ADDR_CONFIG, 32'(256 + 16 * i[1] + i[0]));
    apb(1'b1, `ADDR_OUT_ASSIGN, 32'(asg_tab[i]));
    apb(1'b1, `ADDR_APPROACH, 32'(ap));
    apb(1'b1, `ADDR_LEAVE, 32'(lv));
    apb(1'b1, `ADDR_OFF_HIGH, 32'(hi));
    apb(1'b1, `ADDR_OFF_LOW, 32'(lo));
    pcycle();
    try_start(2, 1'b1);
    `CHECK("dir", i[0], motion.dir)
    `CHECK("speed", ap, motion.speed)
    `CHECK("done_n", 3'h7, done_n)
    apb(1'b1, `ADDR_CTRL_MODE, 32'h1);
    apb(1'b0, `ADDR_CTRL_MODE, 32'h0);
    `CHECK("mode", 32'h0, v)
    apb(1'b0, `ADDR_STATUS, 32'h0);
    `CHECK("refused", 2'h3, {v[8], v[4]})
    apb(1'b1, `ADDR_STATUS, 32'h100);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    `CHECK("clear", 1'b0, v[8])
    for (n = 0; n < 200 && origin !== 1'b1; n++) @(posedge clock_i);
    @(posedge clock_i);
    `CHECK("leave", lv, motion.speed)
    `CHECK("seek", i[0] ^ !i[1], motion.dir)
    pulses = 0;
    for (n = 0; n < 50000 && motion.run === 1'b1; n++) begin
      @(posedge clock_i);
      if (fb === 1'b1) pulses++;
    end
    `CHECK("stop", 1'b0, motion.run)
    `CHECK("offset", 1'b1, pulses - lo - 10000 * hi inside {0, 1})
    `CHECK("done_n", exp_done(asg_tab[i]), done_n)
    $display("Test home %0d done", i);
  endtask : home

  task results;
    $display("Counts: checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    repeat (95000) @(posedge clock_i);
    err_count++;
    results();
  end

  initial begin
    {clock_i, rstn_i, psel, penable, pwrite, pcyc} = '0;
    {paddr, pwdata, terms, delay} = '0;
    poscomp = 1'b1;
    void'($urandom(32'heb07));
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    `CHECK("done_n", 3'h7, done_n)
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, (i < 9) ? 8'(4 * i) : (i == 9 ? 8'h24 : 8'h02), 32'h0);
      `CHECK("err", i > 8, e)
      if (i < 9) `CHECK("reset", rst_tab[i], v)
    end
    $display("Test registers done");
    apb(1'b1, `ADDR_APPROACH, 32'hFFF);
    apb(1'b0, `ADDR_APPROACH, 32'h0);
    `CHECK("approach", 32'(`MAX_APPROACH), v)
    apb(1'b1, `ADDR_LEAVE, 32'hFFF);
    apb(1'b0, `ADDR_LEAVE, 32'h0);
    `CHECK("leave", 32'(`MAX_LEAVE), v)
    apb(1'b1, `ADDR_OFF_LOW, 32'hFFFF);
    apb(1'b0, `ADDR_OFF_LOW, 32'h0);
    `CHECK("offset", 32'(`MAX_OFFSET), v)
    $display("Test limits done");
    apb(1'b1, `ADDR_CONFIG, 32'h100);
    try_start(0, 1'b0);
    apb(1'b1, `ADDR_IN_ASSIGN, 32'h12);
    pcycle();
    try_start(0, 1'b0);
    poscomp <= 1'b0;
    try_start(2, 1'b0);
    poscomp <= 1'b1;
    apb(1'b1, `ADDR_CTRL_MODE, 32'h1);
    try_start(2, 1'b0);
    apb(1'b1, `ADDR_CTRL_MODE, 32'h0);
    $display("Test refusals done");
    for (int i = 0; i < 4; i++) home(i);
    results();
  end
endmodule : servo_homing_sequencer_tb
